// file: rtl/tsw_dpram.sv
// simple dual-port memory with registered read data
module tsw_dpram #(
    parameter int W  = 8,
    parameter int AW = 12
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // read port
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);
    logic [W-1:0] mem [2**AW];

    always_ff @(posedge clk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= '0;
        else
            rdata <= mem[raddr];
    end
endmodule

// file: rtl/tsw_pkg.sv
// constants, field layouts and helper functions for the stream switch port
package tsw_pkg;

    // stream and channel geometry
    localparam int NSTREAM    = 16;
    localparam int STR_W      = 4;
    localparam int CH_W       = 7;
    localparam int POS_W      = 11;
    localparam int SRC_W      = STR_W + CH_W;
    localparam int DM_AW      = 1 + SRC_W;
    localparam int CM_AW      = SRC_W;
    localparam int BYTE_W     = 8;
    localparam int PADDR_W    = 14;

    // register byte addresses
    localparam logic [PADDR_W-1:0] ADDR_IMS  = 14'h0000;
    localparam logic [PADDR_W-1:0] ADDR_BLK  = 14'h0004;
    localparam logic [PADDR_W-1:0] ADDR_OFS  = 14'h0040;
    localparam logic [PADDR_W-1:0] ADDR_MEAS = 14'h0080;
    localparam int                 CM_WIN_BIT = 13;

    // input mode select register fields
    localparam int IMS_BLK    = 2;
    localparam int IMS_MEAS   = 3;
    localparam int IMS_STR_LO = 4;

    // connection memory entry fields
    localparam int CM_MSG     = 11;
    localparam int CM_CONST   = 12;
    localparam int CM_HIZ     = 13;
    localparam int CM_W       = 14;

    // reset values and counts
    localparam logic [1:0]      RATE_RST   = 2'h0;
    localparam logic [CM_W-1:0] BLK_RST    = 14'h0000;
    localparam logic [3:0]      IDLE_RUN   = 4'h7;
    localparam logic [4:0]      FETCH_LAST = 5'h11;
    localparam logic [3:0]      CHAN_LAST  = 4'hf;
    localparam logic [2:0]      BIT_LAST   = 3'h7;
    localparam logic [CM_AW-1:0] CM_LAST   = 11'h7ff;

    typedef enum logic [1:0] {
        TSW_IDLE = 2'b01,
        TSW_RUN  = 2'b10
    } tsw_phase_t;

    // half-bit positions per frame minus one, per rate code
    function automatic logic [POS_W-1:0] tsw_frame_mask(input logic [1:0] rate);
        unique case (rate)
            2'h0:    tsw_frame_mask = 11'h1ff;
            2'h1:    tsw_frame_mask = 11'h3ff;
            default: tsw_frame_mask = 11'h7ff;
        endcase
    endfunction

    // channels per frame minus one, per rate code
    function automatic logic [CH_W-1:0] tsw_chan_mask(input logic [1:0] rate);
        unique case (rate)
            2'h0:    tsw_chan_mask = 7'h1f;
            2'h1:    tsw_chan_mask = 7'h3f;
            default: tsw_chan_mask = 7'h7f;
        endcase
    endfunction

    // word-aligned hit on a block of sixteen registers
    function automatic logic tsw_blk16_hit(input logic [PADDR_W-1:0] a, input logic [PADDR_W-1:0] base);
        tsw_blk16_hit = (a[PADDR_W-1:6] == base[PADDR_W-1:6]) && (a[1:0] == 2'h0);
    endfunction

endpackage

// file: rtl/tsw_switch_port.sv
// serial stream switch port: framing, input capture, switching, apb registers
// Function
// - any input channel switches to any output channel, 2048/1024/512 channels by rate.
// - streams run at one of three rates chosen by the two-bit rate field in the mode register.
// - with wide select low, either narrow frame pulse polarity is found automatically.
// - with wide select high, a negative-going wide pulse marks the frame.
// - with wide select low, the shared pin is the frame measurement input.
// - the frame offset of each input stream is measured using the frame evaluation input.
// - each input stream has its own programmable sampling offset.
// - each output channel picks variable or constant throughput delay.
// - each output channel can be put in high impedance; outputs are three-state.
// - in message mode an output channel sends the byte held in connection memory.
// - block programming writes one value to every connection memory entry in one operation.
// - wide select high enables wide-pulse alignment, low selects narrow pulse operation.
// - active-low reset clears counters and registers and floats every serial output.
module tsw_switch_port
    import tsw_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // serial link pins
    input  wire logic               serial_clk,
    input  wire logic               frame_pulse_in,
    input  wire logic               frame_eval_or_aux_clock,
    input  wire logic               wide_frame_select,
    input  wire logic [NSTREAM-1:0] serial_in_streams,
    output logic      [NSTREAM-1:0] serial_out_streams,
    output logic      [NSTREAM-1:0] serial_out_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // pin synchronisers, third stage only for edge finding
    logic [19:0] sync1;
    logic [19:0] sync2;
    logic [2:0]  sync3;
    wire  [19:0] pin_raw = {wide_frame_select, frame_eval_or_aux_clock, frame_pulse_in, serial_clk,
                            serial_in_streams};

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // frame and evaluation pins idle high, so no false edge after reset
            sync1 <= 20'h60000;
            sync2 <= 20'h60000;
            sync3 <= 3'h6;
        end
        else
        begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2[18:16];
        end
    end

    wire [NSTREAM-1:0] sin       = sync2[NSTREAM-1:0];
    wire               fp        = sync2[17];
    wire               wide      = sync2[19];
    wire               sclk_rise = sync2[16] & ~sync3[0];
    wire               fp_fall   = ~sync2[17] & sync3[1];
    wire               fe_rise   = sync2[18] & ~sync3[2];
    wire               fe_fall   = ~sync2[18] & sync3[2];

    // registers and shared state
    logic [1:0]            rate;
    logic [CM_W-1:0]       blk_val;
    logic [POS_W-1:0]      ofs [NSTREAM];
    logic [POS_W-1:0]      meas_val [NSTREAM];
    logic [STR_W-1:0]      meas_str;
    logic                  meas_arm;
    logic                  meas_run;
    logic                  meas_done;
    logic [POS_W-1:0]      meas_cnt;
    tsw_phase_t            bp_st;
    logic [CM_AW-1:0]      bp_idx;
    logic [POS_W-1:0]      edge_cnt;
    logic                  bank;
    logic                  locked;
    logic                  fp_prev;
    logic [3:0]            run_cnt;
    logic                  idle_lvl;
    logic                  idle_known;
    logic                  wide_armed;

    wire [POS_W-1:0] fmask   = tsw_frame_mask(rate);
    wire [CH_W-1:0]  cmask   = tsw_chan_mask(rate);
    wire             bp_busy = (bp_st == TSW_RUN);
    wire             fmt_alt = ~idle_lvl;

    // apb decode
    wire             acc       = psel & penable;
    wire             ims_hit   = (paddr == ADDR_IMS);
    wire             blk_hit   = (paddr == ADDR_BLK);
    wire             ofs_hit   = tsw_blk16_hit(paddr, ADDR_OFS);
    wire             meas_hit  = tsw_blk16_hit(paddr, ADDR_MEAS);
    wire             cm_hit    = paddr[CM_WIN_BIT] & (paddr[1:0] == 2'h0);
    wire             map_hit   = ims_hit | blk_hit | ofs_hit | meas_hit | cm_hit;
    wire             wait_cond = cm_hit & pwrite & bp_busy;
    wire             do_wr     = acc & pready & pwrite & map_hit;
    wire [STR_W-1:0] ridx      = paddr[5:2];
    wire             blk_start = do_wr & ims_hit & pwdata[IMS_BLK];
    wire             meas_go   = do_wr & ims_hit & pwdata[IMS_MEAS];
    wire [31:0]      ims_rd    = {20'h0, wide, locked, fmt_alt, meas_done, meas_str,
                                  meas_arm | meas_run, bp_busy, rate};
    wire [31:0]      rd_mux    = ims_hit  ? ims_rd :
                                 blk_hit  ? {18'h0, blk_val} :
                                 ofs_hit  ? {21'h0, ofs[ridx]} :
                                 meas_hit ? {21'h0, meas_val[ridx]} : 32'h0;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= acc & ~pready & ~wait_cond;
            pslverr <= acc & ~pready & ~wait_cond & ~map_hit;
            prdata  <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rate    <= RATE_RST;
            blk_val <= BLK_RST;
        end
        else if (do_wr & ims_hit)
            rate <= pwdata[1:0];
        else if (do_wr & blk_hit)
            blk_val <= pwdata[CM_W-1:0];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ofs <= '{default: '0};
        else
            for (int i = 0; i < NSTREAM; i++)
                if (do_wr & ofs_hit & (ridx == STR_W'(i)))
                    ofs[i] <= pwdata[POS_W-1:0];
    end

    // frame pulse polarity: the level that persists is idle, the other is the pulse
    wire narrow_start = sclk_rise & idle_known & (fp != idle_lvl) & (fp_prev == idle_lvl);
    wire wide_start   = wide_armed & fe_rise & ~fp;
    wire frame_start  = wide ? wide_start : narrow_start;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fp_prev    <= 1'b1;
            run_cnt    <= '0;
            idle_lvl   <= 1'b1;
            idle_known <= 1'b0;
        end
        else if (sclk_rise)
        begin
            fp_prev <= fp;
            run_cnt <= (fp != fp_prev) ? 4'h0 : (run_cnt == IDLE_RUN) ? run_cnt : run_cnt + 4'h1;
            if (run_cnt == IDLE_RUN)
            begin
                idle_lvl   <= fp_prev;
                idle_known <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wide_armed <= 1'b0;
            edge_cnt   <= '0;
            bank       <= 1'b0;
            locked     <= 1'b0;
        end
        else
        begin
            wide_armed <= wide & (fp_fall | (wide_armed & ~wide_start));
            if (frame_start)
            begin
                edge_cnt <= '0;
                bank     <= ~bank;
                locked   <= 1'b1;
            end
            else if (sclk_rise)
                edge_cnt <= (edge_cnt + 11'h1) & fmask;
        end
    end

    // input capture: each stream samples at mid-bit of its own shifted frame
    logic [BYTE_W-1:0] ish [NSTREAM];
    logic [BYTE_W-1:0] hold [NSTREAM];
    logic [CH_W-1:0]   hold_ch [NSTREAM];
    logic              hold_bank [NSTREAM];
    logic [NSTREAM-1:0] pend;
    logic [STR_W-1:0]  widx;
    wire  [POS_W-1:0]  ipos [NSTREAM];
    wire  [NSTREAM-1:0] pend_set;

    for (genvar g = 0; g < NSTREAM; g++)
    begin : g_in
        assign ipos[g]     = (edge_cnt - ofs[g]) & fmask;
        assign pend_set[g] = sclk_rise & locked & ipos[g][0] & (ipos[g][3:1] == BIT_LAST);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ish       <= '{default: '0};
            hold      <= '{default: '0};
            hold_ch   <= '{default: '0};
            hold_bank <= '{default: 1'b0};
        end
        else
            for (int i = 0; i < NSTREAM; i++)
                if (sclk_rise & locked & ipos[i][0])
                begin
                    ish[i] <= {ish[i][BYTE_W-2:0], sin[i]};
                    if (pend_set[i])
                    begin
                        hold[i]      <= {ish[i][BYTE_W-2:0], sin[i]};
                        hold_ch[i]   <= ipos[i][POS_W-1:4];
                        hold_bank[i] <= bank;
                    end
                end
    end

    wire                pend_take  = pend[widx];
    wire [NSTREAM-1:0]  pend_clr   = pend_take ? (16'h0001 << widx) : 16'h0000;
    wire [NSTREAM-1:0]  next_pend  = pend_set | (pend & ~pend_clr);
    wire [DM_AW-1:0]    dm_waddr   = {hold_bank[widx], widx, hold_ch[widx]};

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend <= '0;
            widx <= '0;
        end
        else
        begin
            pend <= next_pend;
            widx <= widx + 4'h1;
        end
    end

    // connection memory: block programming owns the write port while it runs
    wire               cm_we    = bp_busy | (do_wr & cm_hit);
    wire [CM_AW-1:0]   cm_waddr = bp_busy ? bp_idx : paddr[CM_AW+1:2];
    wire [CM_W-1:0]    cm_wdata = bp_busy ? blk_val : pwdata[CM_W-1:0];

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bp_st  <= TSW_IDLE;
            bp_idx <= '0;
        end
        else
        begin
            unique case (bp_st)
                TSW_IDLE:
                    if (blk_start)
                        bp_st <= TSW_RUN;
                TSW_RUN:
                    if (bp_idx == CM_LAST)
                        bp_st <= TSW_IDLE;
                default:
                    bp_st <= TSW_IDLE;
            endcase
            bp_idx <= bp_busy ? bp_idx + 11'h1 : '0;
        end
    end

    // output fetch: one channel ahead, sixteen streams pipelined
    tsw_phase_t        fst;
    logic [4:0]        fk;
    logic [CH_W-1:0]   fch;
    logic [CM_W-1:0]   ctrl_p;
    logic [BYTE_W-1:0] nbyte [NSTREAM];
    logic [NSTREAM-1:0] nhiz;
    logic [BYTE_W-1:0] osh [NSTREAM];
    wire  [CM_W-1:0]   cm_rd;
    wire  [BYTE_W-1:0] dm_rd;
    wire               bitstart  = sclk_rise & locked & edge_cnt[0];
    wire               load_chan = bitstart & (edge_cnt[3:0] == CHAN_LAST);
    wire               store_en  = (fst == TSW_RUN) & (fk >= 5'h2);
    wire [STR_W-1:0]   st_idx    = 4'(fk - 5'h2);
    wire               src_early = cm_rd[CH_W-1:0] < fch;
    wire               bank_sel  = (cm_rd[CM_CONST] | ~src_early) ? ~bank : bank;
    wire [DM_AW-1:0]   dm_raddr  = {bank_sel, cm_rd[SRC_W-1:0]};

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fst    <= TSW_IDLE;
            fk     <= '0;
            fch    <= '0;
            ctrl_p <= '0;
        end
        else
        begin
            ctrl_p <= cm_rd;
            unique case (fst)
                TSW_IDLE:
                    if (load_chan)
                    begin
                        fst <= TSW_RUN;
                        fk  <= '0;
                        fch <= (edge_cnt[POS_W-1:4] + 7'h2) & cmask;
                    end
                TSW_RUN:
                begin
                    fk <= fk + 5'h1;
                    if (fk == FETCH_LAST)
                        fst <= TSW_IDLE;
                end
                default:
                    fst <= TSW_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            nbyte <= '{default: '0};
            nhiz  <= '1;
        end
        else if (store_en)
        begin
            nbyte[st_idx] <= ctrl_p[CM_MSG] ? ctrl_p[BYTE_W-1:0] : dm_rd;
            nhiz[st_idx]  <= ctrl_p[CM_HIZ];
        end
    end

    // serial outputs, msb first, floated under reset and per channel
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            osh                <= '{default: '0};
            serial_out_streams <= '0;
            serial_out_oe      <= '0;
        end
        else if (bitstart)
            for (int i = 0; i < NSTREAM; i++)
                if (load_chan)
                begin
                    osh[i]                <= nbyte[i];
                    serial_out_streams[i] <= nbyte[i][BYTE_W-1];
                    serial_out_oe[i]      <= ~nhiz[i];
                end
                else
                begin
                    osh[i]                <= {osh[i][BYTE_W-2:0], 1'b0};
                    serial_out_streams[i] <= osh[i][BYTE_W-2];
                end
    end

    // frame offset measurement, narrow mode only
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meas_str  <= '0;
            meas_arm  <= 1'b0;
            meas_run  <= 1'b0;
            meas_done <= 1'b0;
            meas_cnt  <= '0;
            meas_val  <= '{default: '0};
        end
        else
        begin
            if (meas_go)
                meas_str <= pwdata[IMS_STR_LO +: STR_W];
            meas_arm  <= meas_go | (meas_arm & ~(frame_start & ~wide));
            meas_run  <= ~wide & ((meas_arm & frame_start) | (meas_run & ~fe_fall));
            meas_done <= (meas_run & fe_fall & ~wide) | (meas_done & ~meas_go);
            if (meas_arm & frame_start)
                meas_cnt <= '0;
            else if (meas_run & sclk_rise)
                meas_cnt <= meas_cnt + 11'h1;
            if (meas_run & fe_fall & ~wide)
                meas_val[meas_str] <= meas_cnt;
        end
    end

    tsw_dpram #(.W(BYTE_W), .AW(DM_AW)) u_data_mem (
        .clk   (clk),
        .rst_b (rst_b),
        .we    (pend_take),
        .waddr (dm_waddr),
        .wdata (hold[widx]),
        .raddr (dm_raddr),
        .rdata (dm_rd)
    );

    tsw_dpram #(.W(CM_W), .AW(CM_AW)) u_conn_mem (
        .clk   (clk),
        .rst_b (rst_b),
        .we    (cm_we),
        .waddr (cm_waddr),
        .wdata (cm_wdata),
        .raddr ({fk[STR_W-1:0], fch}),
        .rdata (cm_rd)
    );

    ans_pulse_a: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");
    cm_stall_a: assert property (acc && cm_hit && pwrite && bp_busy |=> !pready)
        else $error("connection write answered during block programming");
    blk_sweep_a: assert property ($rose(bp_busy) |-> bp_idx == '0 ##1 bp_idx == 11'h001)
        else $error("block programming does not start at entry zero");
    blk_end_a: assert property (bp_busy && bp_idx == CM_LAST |=> !bp_busy && !cm_we)
        else $error("block programming did not stop after the last entry");
    wide_start_a: assert property (frame_start && wide |-> fe_rise && !fp && wide_armed)
        else $error("wide frame start without aux clock edge during low pulse");
    narrow_start_a: assert property (frame_start && !wide |-> sclk_rise && fp != idle_lvl)
        else $error("narrow frame start without active pulse level");
    frame_zero_a: assert property (frame_start |=> edge_cnt == '0 && locked && bank != $past(bank))
        else $error("frame start did not realign the bit counter");
    meas_eval_a: assert property ($rose(meas_done) |-> !$past(wide) && $past(fe_fall))
        else $error("measurement finished without evaluation edge in narrow mode");
    hiz_load_a: assert property ($rose(serial_out_oe[0]) |-> $past(load_chan) && !$past(nhiz[0]))
        else $error("output enable changed outside a channel boundary");
    msg_out_a: assert property (store_en && ctrl_p[CM_MSG] |=> nbyte[$past(st_idx)] == $past(ctrl_p[7:0]))
        else $error("message byte not taken from connection memory");
endmodule

// file: verif/tb_tsw_switch_port.sv
// self-checking bench for the stream switch port
module tb_tsw_switch_port
    import tsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               rst_b = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0]        pwdata = '0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               serial_clk;
    logic               frame_pulse_in;
    logic               frame_eval_or_aux_clock;
    logic               wide_frame_select = 1'b0;
    logic               fp_inv = 1'b0;
    logic [NSTREAM-1:0] serial_in_streams;
    logic [NSTREAM-1:0] serial_out_streams;
    logic [NSTREAM-1:0] serial_out_oe;
    logic [10:0]        eval_at = 11'h000;
    logic [31:0]        q;
    int                 errors = 0;
    int                 cmp_count = 0;

    always #20 clk = ~clk;

    tsw_switch_port uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clk(serial_clk), .frame_pulse_in(frame_pulse_in),
        .frame_eval_or_aux_clock(frame_eval_or_aux_clock), .wide_frame_select(wide_frame_select),
        .serial_in_streams(serial_in_streams), .serial_out_streams(serial_out_streams),
        .serial_out_oe(serial_out_oe));

    tsw_far_end far (.eval_at(eval_at), .wide(wide_frame_select), .inv(fp_inv), .serial_clk(serial_clk),
        .frame_pulse_in(frame_pulse_in), .frame_eval_or_aux_clock(frame_eval_or_aux_clock),
        .internal_connection_strap(), .serial_in_streams(serial_in_streams));

    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data masked and compared, error flag compared
    task automatic acc(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] e, input logic ee);
        int i;
        i = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 3000);
        q = prdata & m;
        check({31'h0, pslverr}, {31'h0, ee});
        if (!wr)
            check(q, e);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            errors++;
            print_verdict();
        end
    endtask

    // poll the mode register until the masked bits match, bounded
    task automatic poll(input logic [31:0] m, input logic [31:0] e);
        int i;
        for (i = 0; i < 3000; i++)
        begin
            acc(1'b0, ADDR_IMS, 32'h0, m, e, 1'b0);
            if (q === e)
                break;
            cmp_count--;
            errors--;
        end
        if (i >= 3000)
        begin
            errors++;
            print_verdict();
        end
    endtask

    // skip one frame, then watch stream 0 for a frame
    task automatic watch(input logic on, input logic v);
        int n_on;
        int n_bad;
        n_on = 0;
        n_bad = 0;
        repeat (4400) @(posedge clk);
        repeat (4400)
        begin
            @(posedge clk);
            if (serial_out_oe[0] === 1'b1)
                n_on++;
            if (serial_out_oe[0] === 1'b1 && serial_out_streams[0] !== v)
                n_bad++;
        end
        check({31'h0, n_on != 0}, {31'h0, on});
        check(32'(n_bad), 32'h0);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        check({serial_out_oe, serial_out_streams}, 32'h0);
        rst_b <= 1'b1;
        acc(1'b0, ADDR_IMS, 32'h0, 32'h3, 32'h0, 1'b0);
        acc(1'b1, ADDR_IMS, 32'h1, 32'h0, 32'h0, 1'b0);
        acc(1'b0, ADDR_IMS, 32'h0, 32'h3, 32'h1, 1'b0);
        acc(1'b1, ADDR_IMS, 32'h0, 32'h0, 32'h0, 1'b0);
        acc(1'b1, ADDR_OFS + 14'h000c, 32'h123, 32'h0, 32'h0, 1'b0);
        acc(1'b0, ADDR_OFS + 14'h000c, 32'h0, 32'h7ff, 32'h123, 1'b0);
        acc(1'b0, 14'h1000, 32'h0, 32'hffffffff, 32'h0, 1'b1);
        acc(1'b0, 14'h2000, 32'h0, 32'hffffffff, 32'h0, 1'b0);
        poll(32'h400, 32'h400);
        acc(1'b0, ADDR_IMS, 32'h0, 32'he00, 32'h400, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            acc(1'b1, ADDR_BLK, {18'h0, i == 0, 1'b0, i != 0, 3'h0, {8{i == 1}}}, 0, 0, 1'b0);
            acc(1'b0, ADDR_BLK, 32'h0, 32'h3fff, {18'h0, pwdata[13:0]}, 1'b0);
            acc(1'b1, ADDR_IMS, 32'h4, 32'h0, 32'h0, 1'b0);
            poll(32'h4, 32'h0);
            watch(i != 0, i == 1);
        end
        eval_at <= 11'd40;
        acc(1'b1, ADDR_IMS, 32'h28, 32'h0, 32'h0, 1'b0);
        poll(32'h100, 32'h100);
        acc(1'b0, ADDR_MEAS + 14'h0008, 32'h0, 32'h7ff, 32'h0, 1'b0);
        errors = (q >= 32'd38 && q <= 32'd42) ? errors - 1 : errors;
        check({31'h0, q >= 32'd38 && q <= 32'd42}, 32'h1);
        fp_inv <= 1'b1;
        poll(32'h200, 32'h200);
        wide_frame_select <= 1'b1;
        poll(32'h800, 32'h800);
        watch(1'b1, 1'b0);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        check({serial_out_oe, serial_out_streams}, 32'h0);
        rst_b <= 1'b1;
        acc(1'b0, ADDR_IMS, 32'h0, 32'h1ff, 32'h0, 1'b0);
        print_verdict();
    end
endmodule

// file: verif/tsw_far_end.sv
// far-end framer: serial clock, narrow or wide frame pulse, evaluation pulse or aux clock, input data
module tsw_far_end #(
    parameter int FRAME = 512
) (
    // evaluation fall point from the bench, 0 = never
    input  wire logic [10:0] eval_at,
    // frame format: wide pulse with aux clock, inverted narrow pulse
    input  wire logic        wide,
    input  wire logic        inv,
    // link pins
    output logic             serial_clk,
    output logic             frame_pulse_in,
    output logic             frame_eval_or_aux_clock,
    output logic             internal_connection_strap,
    output logic [15:0]      serial_in_streams
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial
    begin
        serial_clk = 1'b0;
        frame_pulse_in = 1'b1;
        frame_eval_or_aux_clock = 1'b1;
        internal_connection_strap = 1'b0;
        serial_in_streams = 16'h0000;
    end
    always #160 serial_clk = ~serial_clk;
    always @(posedge serial_clk)
    begin
        cnt <= (cnt + 1) % FRAME;
        if (wide)
            frame_eval_or_aux_clock <= 1'b1;
    end
    always @(negedge serial_clk)
    begin
        frame_pulse_in <= wide ? (cnt != FRAME - 1 && cnt != 0) : ((cnt != FRAME - 1) ^ inv);
        frame_eval_or_aux_clock <= !(wide || (eval_at != 11'h000 && cnt >= eval_at));
        serial_in_streams <= {8{cnt[2], cnt[1]}};
    end
endmodule
